// file: design/tcf_defs.svh
// Register offsets, field positions and reset values of the cross-trigger block
`ifndef TCF_DEFS_SVH
`define TCF_DEFS_SVH

// Register byte offsets
`define TCF_OFS_PRESCALE_COUNT_READBACK 16'h1110
`define TCF_OFS_CROSS_TRIGGER_CONTROL   16'h1114
`define TCF_OFS_SOFTWARE_CROSS_TRIGGER  16'h111c
`define TCF_OFS_FAULT_SOURCE_ENABLE     16'h1120
`define TCF_OFS_EVENT_STATUS            16'h1140
`define TCF_OFS_EVENT_MASK              16'h1144
`define TCF_OFS_FAULT_PATH_SELECT       16'h1148

// Cross trigger control fields
`define TCF_XOUT_EN_BIT   0
`define TCF_XIN_EN_BIT    1
`define TCF_XSEL_LSB      16
`define TCF_XSEL_MSB      19
`define TCF_XSEL_MAX      4'hb
`define TCF_SWTRIG_BIT    0

// Fault source fields: clock fault, comparators 0..2, pins 0..2
`define TCF_FS_MSB        6
`define TCF_FS_W          7

// Event status bits
`define TCF_ST_XOUT       0
`define TCF_ST_XIN        1
`define TCF_ST_FAULT      2
`define TCF_ST_MSB        2

// Byte lanes holding fields
`define TCF_LANE_LO       0
`define TCF_LANE_SEL      2

`define TCF_RST_WORD      32'h0000_0000
`define TCF_PSC_ONE       8'h01

`endif

// file: design/tcf_fault_if.sv
// Interface between the register block and the fault source selector
`timescale 1ns/100ps
`default_nettype none
`include "tcf_defs.svh"

interface tcf_fault_if;
    logic [`TCF_FS_MSB:0] src;
    logic [`TCF_FS_MSB:0] en;
    logic [`TCF_FS_MSB:0] async_sel;
    logic                 hit;

    modport core (output src, output en, output async_sel, input hit);
    modport sel  (input src, input en, input async_sel, output hit);
endinterface

`default_nettype wire

// file: design/tcf_fault_sel.sv
// Fault source path selection, masking and combining
`timescale 1ns/100ps
`default_nettype none
`include "tcf_defs.svh"

module tcf_fault_sel (
    // Clock and reset
    input  wire logic   clk_sys,
    input  wire logic   rst_b,
    // Fault sources and controls
    tcf_fault_if.sel    flt
);
    import tcf_pkg::*;

    tcf_sync_t            s;
    tcf_sync_t            n;
    logic [`TCF_FS_MSB:0] path;
    logic [`TCF_FS_MSB:0] masked;

    always_comb begin
        n    = s;
        n.s1 = flt.src;
        n.s2 = s.s1;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // Async path trades glitch immunity for the two-cycle synchroniser delay
    genvar i;
    generate
        for (i = 0; i < `TCF_FS_W; i++) begin : g_src
            assign path[i]   = flt.async_sel[i] ? flt.src[i] : s.s2[i]; // see RQ9
            assign masked[i] = path[i] & flt.en[i]; // see RQ10 // see RQ11 // see RQ12
        end
    endgenerate

    assign flt.hit = |masked; // see RQ14
endmodule

`default_nettype wire

// file: design/tcf_pkg.sv
// Types shared by the cross-trigger and fault select modules
`include "tcf_defs.svh"

package tcf_pkg;

    // State of the top module, apart from the fault synchroniser
    typedef struct packed {
        logic [7:0]             psc;
        logic                   psc_tick;
        logic [3:0]             xsel;
        logic                   xin_en;
        logic                   xout_en;
        logic                   swtrig;
        logic [`TCF_FS_MSB:0]   fs_en;
        logic [`TCF_FS_MSB:0]   fs_async;
        logic [`TCF_ST_MSB:0]   st;
        logic [`TCF_ST_MSB:0]   msk;
        logic                   irq;
        logic                   xtrig_out;
        logic                   ctr_en_set;
        logic                   fault;
        logic                   pready;
        logic                   pslverr;
        logic [31:0]            prdata;
    } tcf_state_t;

    // State of the fault synchroniser
    typedef struct packed {
        logic [`TCF_FS_MSB:0]   s1;
        logic [`TCF_FS_MSB:0]   s2;
    } tcf_sync_t;

endpackage

// file: design/tcf_top.sv
// Timer prescaler readback, cross-trigger control and fault source select
//
// Added by the designer: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "tcf_defs.svh"

// Functional notes
// RQ1: Prescaler down-count is readable live as an 8-bit read-only field.
// RQ2: Four-bit selector picks the input trigger source among twelve events.
// RQ3: Input trigger enable lets the selected event act as cross trigger.
// RQ4: Cross-trigger enable gates every cross-trigger output; zero means none.
// RQ5: Cross-trigger output feeds sibling timers, which take it as a start.
// RQ6: Cross-trigger out equals the hardware and software counter enable conditions.
// RQ7: Writing one to software trigger makes one synced pulse, self included.
// RQ8: Cross-trigger control covers counter enables and shared fault signals; the code shares only counter enables, timer_fault stays local.
// RQ9: Each fault input takes a synchronous or an asynchronous path.
// RQ10: Bits 6, 5, 4 enable external fault pins 2, 1, 0.
// RQ11: Bits 3, 2, 1 enable comparator outputs 2, 1, 0.
// RQ12: Bit 0 enables the system clock fault as a timer fault.
// RQ13: An incoming cross trigger can set the counter enable, besides software.
// RQ14: Timer fault is the OR of all enabled active sources.
// RQ15: All control and fault enable bits reset to zero.

module tcf_top #(
    parameter int NUM_PEERS = 2,
    parameter int AW        = 16
) (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst_b,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [AW-1:0]        paddr,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Counter core
    input  wire logic                 ctr_run,
    input  wire logic                 ctr_en_sw_set,
    input  wire logic [7:0]           prescale_div,
    output logic                      prescale_tick,
    output logic                      ctr_en_set,
    // Timer events usable as input trigger
    input  wire logic                 subscriber_port_zero,
    input  wire logic                 subscriber_port_one,
    input  wire logic                 evt_zero,
    input  wire logic                 evt_load,
    input  wire logic [3:0]           compare_down_event,
    input  wire logic [3:0]           compare_up_event,
    // Cross trigger with sibling timers
    input  wire logic [NUM_PEERS-1:0] xtrig_in,
    output logic                      xtrig_out,
    // Fault sources
    input  wire logic [2:0]           ext_fault_pin,
    input  wire logic [2:0]           comparator_output,
    input  wire logic                 clk_fault,
    output logic                      timer_fault,
    // Interrupt
    output logic                      irq
);
    import tcf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////

    generate
        if (NUM_PEERS < 1) begin : g_chk_peers
            $error("NUM_PEERS must be at least one");
        end
        if (AW < 13) begin : g_chk_aw
            $error("AW too narrow for the register offsets");
        end
    endgenerate

    tcf_state_t            s;
    tcf_state_t            n;
    tcf_fault_if           flt ();

    logic [11:0]           evt_vec;
    logic                  sel_evt;
    logic                  hw_cond;
    logic                  sw_cond;
    logic                  start;
    logic                  setup;
    logic                  wr_acc;
    logic [15:0]           addr;
    logic [`TCF_ST_MSB:0]  ev;
    logic [`TCF_ST_MSB:0]  clr;

    // Offsets are compared on the low 16 address bits
    assign addr = 16'(paddr);

    ////////////////////////////////////////////////////////////////////////////////
    // Trigger source selection

    assign evt_vec = {compare_up_event, compare_down_event, evt_load, evt_zero,
                      subscriber_port_one, subscriber_port_zero};

    // Codes above the last event select nothing
    always_comb begin
        if (s.xsel <= `TCF_XSEL_MAX) begin
            sel_evt = evt_vec[s.xsel]; // see RQ2
        end else begin
            sel_evt = 1'b0;
        end
    end

    assign hw_cond = s.xin_en & sel_evt; // see RQ3
    // Software trigger reaches this timer only when it is cross-trigger enabled
    assign sw_cond = ctr_en_sw_set | (s.swtrig & s.xout_en); // see RQ7
    // Peer triggers start this timer but are not echoed, avoiding a ring
    assign start   = hw_cond | sw_cond | (|xtrig_in); // see RQ5 // see RQ13

    ////////////////////////////////////////////////////////////////////////////////
    // Fault source selector

    assign flt.src       = {ext_fault_pin, comparator_output, clk_fault};
    assign flt.en        = s.fs_en;
    assign flt.async_sel = s.fs_async;

    tcf_fault_sel u_fault_sel (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .flt     (flt.sel)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    assign setup  = psel & ~penable;
    assign wr_acc = psel & penable & pwrite & s.pready;

    always_comb begin
        n            = s;
        n.swtrig     = 1'b0;
        n.pready     = 1'b0;
        n.pslverr    = 1'b0;
        clr          = '0;

        // Prescaler down-count, reloaded while the counter is stopped
        if (!ctr_run) begin
            n.psc      = prescale_div;
            n.psc_tick = 1'b0;
        end else if (s.psc == 8'h00) begin
            n.psc      = prescale_div;
            n.psc_tick = 1'b1;
        end else begin
            n.psc      = s.psc - `TCF_PSC_ONE;
            n.psc_tick = 1'b0;
        end

        // Cross trigger and counter enable requests
        n.xtrig_out  = s.xout_en & (hw_cond | sw_cond); // see RQ4 // see RQ6
        n.ctr_en_set = start; // see RQ13
        n.fault      = flt.hit; // see RQ8 // see RQ14

        // Register read in the setup phase; answer stands in the access phase
        if (setup) begin
            n.pready = 1'b1;
            n.prdata = `TCF_RST_WORD;
            if (addr == `TCF_OFS_PRESCALE_COUNT_READBACK) begin
                n.prdata[7:0] = s.psc; // see RQ1
            end else if (addr == `TCF_OFS_CROSS_TRIGGER_CONTROL) begin
                n.prdata[`TCF_XSEL_MSB:`TCF_XSEL_LSB] = s.xsel;
                n.prdata[`TCF_XIN_EN_BIT]             = s.xin_en;
                n.prdata[`TCF_XOUT_EN_BIT]            = s.xout_en;
            end else if (addr == `TCF_OFS_SOFTWARE_CROSS_TRIGGER) begin
                n.prdata = `TCF_RST_WORD;
            end else if (addr == `TCF_OFS_FAULT_SOURCE_ENABLE) begin
                n.prdata[`TCF_FS_MSB:0] = s.fs_en;
            end else if (addr == `TCF_OFS_EVENT_STATUS) begin
                n.prdata[`TCF_ST_MSB:0] = s.st;
            end else if (addr == `TCF_OFS_EVENT_MASK) begin
                n.prdata[`TCF_ST_MSB:0] = s.msk;
            end else if (addr == `TCF_OFS_FAULT_PATH_SELECT) begin
                n.prdata[`TCF_FS_MSB:0] = s.fs_async;
            end else begin
                n.pslverr = 1'b1;
            end
        end

        // Writes take effect at the access-phase edge
        if (wr_acc) begin
            if (addr == `TCF_OFS_CROSS_TRIGGER_CONTROL) begin
                if (pstrb[`TCF_LANE_SEL]) begin
                    n.xsel = pwdata[`TCF_XSEL_MSB:`TCF_XSEL_LSB]; // see RQ2
                end
                if (pstrb[`TCF_LANE_LO]) begin
                    n.xin_en  = pwdata[`TCF_XIN_EN_BIT]; // see RQ3
                    n.xout_en = pwdata[`TCF_XOUT_EN_BIT]; // see RQ4
                end
            end else if (addr == `TCF_OFS_SOFTWARE_CROSS_TRIGGER) begin
                if (pstrb[`TCF_LANE_LO]) begin
                    n.swtrig = pwdata[`TCF_SWTRIG_BIT]; // see RQ7
                end
            end else if (addr == `TCF_OFS_FAULT_SOURCE_ENABLE) begin
                if (pstrb[`TCF_LANE_LO]) begin
                    n.fs_en = pwdata[`TCF_FS_MSB:0]; // see RQ10 // see RQ11 // see RQ12
                end
            end else if (addr == `TCF_OFS_EVENT_STATUS) begin
                if (pstrb[`TCF_LANE_LO]) begin
                    clr = pwdata[`TCF_ST_MSB:0];
                end
            end else if (addr == `TCF_OFS_EVENT_MASK) begin
                if (pstrb[`TCF_LANE_LO]) begin
                    n.msk = pwdata[`TCF_ST_MSB:0];
                end
            end else if (addr == `TCF_OFS_FAULT_PATH_SELECT) begin
                if (pstrb[`TCF_LANE_LO]) begin
                    n.fs_async = pwdata[`TCF_FS_MSB:0]; // see RQ9
                end
            end
        end

        // Sticky events; a set in the clearing cycle survives
        ev                = '0;
        ev[`TCF_ST_XOUT]  = n.xtrig_out;
        ev[`TCF_ST_XIN]   = |xtrig_in;
        ev[`TCF_ST_FAULT] = flt.hit & ~s.fault;
        n.st              = (s.st & ~clr) | ev;
        n.irq             = |(n.st & n.msk);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0; // see RQ15
        end else begin
            s <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata        = s.prdata;
    assign pready        = s.pready;
    assign pslverr       = s.pslverr;
    assign prescale_tick = s.psc_tick;
    assign ctr_en_set    = s.ctr_en_set;
    assign xtrig_out     = s.xtrig_out;
    assign timer_fault   = s.fault;
    assign irq           = s.irq;

endmodule

`default_nettype wire

// file: tb/tb_tcf_top.sv
// Self-checking bench for the cross-trigger and fault select block
`timescale 1ns/100ps
`default_nettype none

module tb_tcf_top;
    logic clk_sys = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, e;
    logic ctr_run = 0, ctr_en_sw_set = 0, pready, pslverr, xtrig_out, ctr_en_set;
    logic timer_fault, irq, tick;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [7:0]  prescale_div = 8'h0, lf = 8'h3d;
    logic [11:0] ev = 12'h0;
    logic [6:0]  fs = 7'h0, en;
    logic [1:0]  fire = 2'h0, xtrig_in;
    int err_total = 0, total_checks = 0, nx, ne, starts, s;
    always #2 clk_sys = ~clk_sys;

    tcf_top tcf_top_inst (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ctr_run(ctr_run), .ctr_en_sw_set(ctr_en_sw_set),
        .prescale_div(prescale_div), .prescale_tick(tick), .ctr_en_set(ctr_en_set),
        .subscriber_port_zero(ev[0]), .subscriber_port_one(ev[1]), .evt_zero(ev[2]),
        .evt_load(ev[3]), .compare_down_event(ev[7:4]), .compare_up_event(ev[11:8]),
        .xtrig_in(xtrig_in), .xtrig_out(xtrig_out), .ext_fault_pin(fs[6:4]),
        .comparator_output(fs[3:1]), .clk_fault(fs[0]), .timer_fault(timer_fault), .irq(irq));
    tcf_peer_model tcf_peer_model_inst (.clk_sys(clk_sys), .rst_b(rst_b), .fire(fire),
        .dut_xtrig(xtrig_out), .xtrig(xtrig_in), .starts(starts));
    ////////////////////////////////////////////////////////////////////////////
    function logic [7:0] nxt(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    function logic fexp(input logic [6:0] a, input logic [6:0] b);
        return |(a & b);
    endfunction
    task chk(input logic [31:0] sn, input logic [31:0] x);
        total_checks++;
        if (sn !== x) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, sn, x);
        end
    endtask
    task report_and_stop;
        $display("checks=%0d mismatches=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Holds the request until pready is seen; only the watchdog ends a wait
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        r = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task rd(input logic [15:0] a, input logic [31:0] x);
        apb(0, a, 32'h0);
        chk(r, x);
    endtask
    task watch(input int n);
        nx = 0; ne = 0;
        repeat (n) begin
            @(posedge clk_sys);
            nx += int'(xtrig_out === 1'b1);
            ne += int'(ctr_en_set === 1'b1);
        end
    endtask
    task pulse_ev(input logic [11:0] v);
        @(posedge clk_sys); ev <= v;
        @(posedge clk_sys); ev <= 12'h0;
        watch(4);
    endtask
    initial begin
        #80000;
        err_total++;
        report_and_stop;
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_b <= 1;
        rd(16'h1114, 32'h0); rd(16'h1120, 32'h0); rd(16'h1144, 32'h0);
        repeat (4) begin
            lf = nxt(lf); prescale_div <= lf; repeat (2) @(posedge clk_sys);
            rd(16'h1110, {24'h0, lf});
        end
        apb(1, 16'h1110, 32'hffffffff); rd(16'h1110, {24'h0, lf});
        // Running counter has taken one step down from the loaded value when read
        prescale_div <= 8'h0; ctr_run <= 1; rd(16'h1110, {24'h0, lf - 8'h1}); ctr_run <= 0;
        // A reload value of 3 gives one tick every 4 cycles while running
        @(posedge clk_sys);
        prescale_div <= 8'h3;
        ctr_run <= 1;
        nx = 0;
        repeat (40) begin
            @(posedge clk_sys);
            nx += int'(tick === 1'b1);
        end
        ctr_run <= 0;
        chk(nx, 10);
        apb(1, 16'h1114, 32'hffffffff); rd(16'h1114, 32'h000f0003);
        apb(1, 16'h1120, 32'hffffffff); rd(16'h1120, 32'h0000007f);
        rd(16'h111c, 32'h0);
        apb(0, 16'h1118, 32'h0); chk(e, 1); chk(r, 0);
        $display("registers done");
        for (int c = 0; c < 12; c++) begin
            apb(1, 16'h1114, (c << 16) | 3);
            pulse_ev(~(12'h1 << c)); chk(nx, 0);
            pulse_ev(12'h1 << c); chk(nx, 1);
        end
        apb(1, 16'h1114, 32'h2); pulse_ev(12'h1); chk(nx, 0); chk(ne, 1);
        apb(1, 16'h1114, 32'h1); pulse_ev(12'h1); chk(nx + ne, 0);
        s = starts; apb(1, 16'h111c, 32'h1); watch(5);
        chk(nx, 1); chk(ne, 1); chk(starts - s, 1);
        apb(1, 16'h111c, 32'h0); watch(5); chk(nx, 0);
        @(posedge clk_sys); ctr_en_sw_set <= 1; @(posedge clk_sys); ctr_en_sw_set <= 0;
        watch(4); chk(nx, 1);
        apb(1, 16'h1114, 32'h0); apb(1, 16'h111c, 32'h1); watch(5); chk(nx + ne, 0);
        for (int p = 0; p < 2; p++) begin
            @(posedge clk_sys); fire <= 2'(1 << p); @(posedge clk_sys); fire <= 2'h0;
            watch(5); chk(nx, 0); chk(ne, 1);
        end
        $display("cross trigger done");
        for (int i = 0; i < 24; i++) begin
            lf = nxt(lf); en = i < 14 ? 7'(1 << (i / 2)) : lf[6:0];
            apb(1, 16'h1120, 32'(en));
            lf = nxt(lf); apb(1, 16'h1148, 32'(lf[6:0]));
            lf = nxt(lf);
            @(posedge clk_sys); fs <= i < 14 ? ((i % 2) ? en : ~en) : lf[6:0];
            repeat (5) @(posedge clk_sys);
            chk(timer_fault, fexp(en, fs));
        end
        $display("fault select done");
        apb(1, 16'h1120, 32'h1); @(posedge clk_sys); fs <= 7'h0; repeat (5) @(posedge clk_sys);
        apb(1, 16'h1144, 32'h0); apb(1, 16'h1140, 32'h7); chk(irq, 0);
        @(posedge clk_sys); fs <= 7'h1; repeat (5) @(posedge clk_sys);
        rd(16'h1140, 32'h4); chk(irq, 0);
        apb(1, 16'h1144, 32'h4); repeat (2) @(posedge clk_sys); chk(irq, 1);
        apb(1, 16'h1140, 32'h4); repeat (2) @(posedge clk_sys); chk(irq, 0);
        rd(16'h1140, 32'h0);
        $display("interrupt done");
        report_and_stop;
    end
endmodule

`default_nettype wire

// file: tb/tcf_checker.sv
// Port-level assertions for the cross-trigger and fault select block
`timescale 1ns/100ps
`default_nettype none

module tcf_checker #(
    parameter int NUM_PEERS = 2,
    parameter int AW        = 16
) (
    input wire logic                 clk_sys,
    input wire logic                 rst_b,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic [AW-1:0]        paddr,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic                 ctr_run,
    input wire logic                 ctr_en_sw_set,
    input wire logic                 prescale_tick,
    input wire logic                 ctr_en_set,
    input wire logic [NUM_PEERS-1:0] xtrig_in,
    input wire logic                 xtrig_out,
    input wire logic [2:0]           ext_fault_pin,
    input wire logic [2:0]           comparator_output,
    input wire logic                 clk_fault,
    input wire logic                 timer_fault
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    logic mapped;
    always_comb mapped = paddr[15:0] inside {16'h1110, 16'h1114, 16'h111c, 16'h1120,
                                             16'h1140, 16'h1144, 16'h1148};
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_quiet;
        !(|ext_fault_pin) && !(|comparator_output) && !clk_fault;
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    chk_ready_after_setup: assert property (s_setup |=> pready)
        else $error("ready missing after setup");
    chk_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_unmapped_err: assert property (s_setup and !mapped |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_mapped_no_err: assert property (s_setup and mapped |=> !pslverr)
        else $error("mapped access refused");
    chk_xout_starts_self: assert property (xtrig_out |-> ctr_en_set)
        else $error("cross trigger out without own start");
    chk_peer_starts: assert property (|xtrig_in |=> ctr_en_set)
        else $error("peer trigger did not start counter");
    chk_sw_en_starts: assert property (ctr_en_sw_set |=> ctr_en_set)
        else $error("software enable not forwarded");
    chk_fault_quiet: assert property (s_quiet [*3] |=> !timer_fault)
        else $error("fault without active source");
    chk_tick_idle: assert property (!ctr_run [*3] |=> !prescale_tick)
        else $error("prescaler ticked while stopped");
endmodule

bind tcf_top tcf_checker #(.NUM_PEERS(NUM_PEERS), .AW(AW)) tcf_checker_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ctr_run(ctr_run),
    .ctr_en_sw_set(ctr_en_sw_set), .prescale_tick(prescale_tick), .ctr_en_set(ctr_en_set),
    .xtrig_in(xtrig_in), .xtrig_out(xtrig_out), .ext_fault_pin(ext_fault_pin),
    .comparator_output(comparator_output), .clk_fault(clk_fault), .timer_fault(timer_fault));

`default_nettype wire

// file: tb/tcf_peer_model.sv
// Two sibling timers sharing the cross-trigger wiring
`timescale 1ns/100ps
`default_nettype none

module tcf_peer_model (
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic [1:0]  fire,
    input wire logic        dut_xtrig,
    output logic [1:0]      xtrig,
    output int              starts
);
    logic fire_dly;
    // Peer 0 answers one cycle after fire, peer 1 a cycle later
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fire_dly <= 1'b0;
            xtrig    <= 2'h0;
            starts   <= 0;
        end else begin
            fire_dly <= fire[1];
            xtrig    <= {fire_dly, fire[0]};
            starts   <= starts + int'(dut_xtrig);
        end
    end
endmodule

`default_nettype wire
